// ### aofd_consts.vh
// Purpose: Constants for the amplifier offset and fault diagnostic control
// Assumes: 200 MHz clock, times in microseconds
// Notes:   Bit positions refer to the control and diagnostic bytes
`ifndef AOFD_CONSTS_VH
`define AOFD_CONSTS_VH

`define AOFD_CLK_MHZ          200
`define AOFD_SSR_MUTE_US      40000
`define AOFD_SSR_MUTE_CYC     ((`AOFD_SSR_MUTE_US * `AOFD_CLK_MHZ) - 1)
`define AOFD_SILENT_US        100000
`define AOFD_SILENT_CYC       (`AOFD_SILENT_US * `AOFD_CLK_MHZ)
`define AOFD_FAST_MUTE_US     1
`define AOFD_FAST_MUTE_CYC    (`AOFD_FAST_MUTE_US * `AOFD_CLK_MHZ)
`define AOFD_CNT_W            25

`define AOFD_CB1_OFFSET_EN    5
`define AOFD_CB1_DIAG_EN      6
`define AOFD_CB2_SSR_EN       0
`define AOFD_CB2_STBY_OFF     4
`define AOFD_CB2_FAST_MUTE    5
`define AOFD_DB2_SSR_SHUT     6
`define AOFD_DB_OFFSET        5
`define AOFD_RESET_BYTE       8'h00

// Per-channel fault code: bit0 gnd, bit1 supply, bit2 across, bit3 open
`define AOFD_F_GND            0
`define AOFD_F_VS             1
`define AOFD_F_ACROSS         2
`define AOFD_F_OPEN           3

`endif

// ### aofd_sync.v
// Purpose: Two flip-flop synchroniser for a vector of pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module aofd_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_reg;

  // Two stages to settle metastability
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= {W{1'b0}};
      q        <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // aofd_sync

// ### aofd_chan.v
// Purpose: One channel fault qualifier over a diagnostic cycle
// Assumes: Fault inputs already synchronised
// Notes:   A fault counts only if seen on every cycle of the period
`timescale 1ns/1ps
`include "aofd_consts.vh"
module aofd_chan (
  input  wire       clk,
  input  wire       rst,
  input  wire       read_pulse,
  input  wire       perm_mode,
  input  wire [3:0] fault_raw,
  input  wire       offset_raw,
  input  wire       overload,
  input  wire       offset_en,
  output reg  [3:0] fault_rep,
  output reg        offset_rep
);
  reg  [3:0] stable_reg;
  reg        off_stable_reg;
  reg        ovl_seen_reg;
  reg  [3:0] masked;

  // Pair priority: a short to either rail hides across and open faults
  always @* begin
    masked = stable_reg;
    if (stable_reg[`AOFD_F_GND] | stable_reg[`AOFD_F_VS]) begin
      masked[`AOFD_F_ACROSS] = 1'b0;
      masked[`AOFD_F_OPEN]   = 1'b0;
    end
    if (perm_mode) begin
      masked[`AOFD_F_OPEN] = 1'b0;
    end
  end

  // Period accumulators re-arm on every read; report holds last period
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stable_reg     <= 4'hF;
      off_stable_reg <= 1'b1;
      ovl_seen_reg   <= 1'b0;
      fault_rep      <= 4'h0;
      offset_rep     <= 1'b0;
    end else if (read_pulse) begin
      fault_rep      <= masked;
      offset_rep     <= off_stable_reg & ~ovl_seen_reg & offset_en;
      stable_reg     <= 4'hF;
      off_stable_reg <= 1'b1;
      ovl_seen_reg   <= 1'b0;
    end else begin
      stable_reg     <= stable_reg & fault_raw;
      off_stable_reg <= off_stable_reg & offset_raw;
      ovl_seen_reg   <= ovl_seen_reg | overload;
    end
  end
endmodule // aofd_chan

// ### aofd_ctrl.v
// Purpose: Speaker safety, offset window and fault reporting control
// Assumes: Host bytes arrive as strobes from the serial bus logic
// Notes:   Standby (pin or command) acts as the functional reset
//
// How it works
// - Offset above 2 V at start mutes within 40 ms
// - Control byte two bit 0 enables safety routine
// - Play checks all channels; clean offset stays active
// - Safety shutdown shows in diag byte two bit 6
// - Standby pin or command clears shutdown and resets
// - Offset window opens at last read or reset
// - Offset flagged only if present whole window
// - Overload in window suppresses offset flag
// - Multiple faults reported over successive read cycles
// - Rail shorts mask across and open faults
// - Permanent diagnostics ignore open loads
// - Fault reported only if stable whole period
// - Every diagnostic cycle re-arms after each read
// - Read data come from previous completed cycle
// - Fast mute bit gives mute under 1.5 ms
// - Three thermal warnings in the diagnostic data
// - Control byte two bit 4 low selects standby
`timescale 1ns/1ps
`include "aofd_consts.vh"
module aofd_ctrl (
  input  wire        clk,
  input  wire        rst,
  input  wire        standby_pin_n,
  input  wire [7:0]  control_byte_one,
  input  wire        cb1_wr,
  input  wire [7:0]  control_byte_two,
  input  wire        cb2_wr,
  input  wire        diag_read,
  input  wire [15:0] fault_pins,
  input  wire [3:0]  offset_pins,
  input  wire [3:0]  overload_pins,
  input  wire [2:0]  thermal_pins,
  output reg         amp_enable,
  output reg         mute_out,
  output reg         fast_mute_out,
  output reg         audio_ready,
  output reg  [7:0]  diag_byte_one,
  output reg  [7:0]  diag_byte_two,
  output reg  [7:0]  diag_byte_three,
  output reg  [7:0]  diag_byte_four
);
  localparam ST_STBY  = 5'b00001;
  localparam ST_MUTED = 5'b00010;
  localparam ST_CHECK = 5'b00100;
  localparam ST_PLAY  = 5'b01000;
  localparam ST_SHUT  = 5'b10000;

  reg  [4:0]  state_reg;
  reg  [4:0]  state_next;
  reg  [7:0]  cb1_reg;
  reg  [7:0]  cb2_reg;
  reg  [`AOFD_CNT_W-1:0] cnt_reg;
  reg  [`AOFD_CNT_W-1:0] cnt_next;
  reg         checked_reg;
  reg         ssr_shut_reg;
  reg         perm_reg;
  reg  [2:0]  therm_reg;
  reg         perm_rep_reg;
  reg         mute_req_reg;
  reg  [`AOFD_CNT_W-1:0] mcnt_reg;

  wire [15:0] fault_s;
  wire [3:0]  offset_s;
  wire [3:0]  ovl_s;
  wire [2:0]  therm_s;
  wire        stby_pin_s;
  wire [15:0] fault_rep;
  wire [3:0]  offset_rep;
  wire        standby;
  wire        play_cmd;
  wire        mute_cmd;
  wire        any_offset;
  wire        ssr_on;
  wire        mute_done;

  // All pin inputs are asynchronous to clk
  aofd_sync #(.W(28)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({standby_pin_n, thermal_pins, overload_pins, offset_pins,
           fault_pins}),
    .q   ({stby_pin_s, therm_s, ovl_s, offset_s, fault_s})
  );

  // Standby from pin or bit 4 of control byte two
  assign standby    = ~stby_pin_s | ~cb2_reg[`AOFD_CB2_STBY_OFF];
  assign play_cmd   = cb1_wr & (control_byte_one[1] | control_byte_one[2]);
  // A write with both unmute bits low asks for mute
  assign mute_cmd   = cb1_wr & ~(control_byte_one[1] | control_byte_one[2]);
  assign any_offset = |offset_s;
  assign ssr_on     = cb2_reg[`AOFD_CB2_SSR_EN];

  // Control byte storage; reset value keeps the amplifier in standby
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cb1_reg <= `AOFD_RESET_BYTE;
      cb2_reg <= `AOFD_RESET_BYTE;
    end else begin
      if (cb1_wr) begin
        cb1_reg <= control_byte_one;
      end
      if (cb2_wr) begin
        cb2_reg <= control_byte_two;
      end
    end
  end

  // Per-channel qualification; a read also rolls the report forward
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ch
      aofd_chan u_chan (
        .clk        (clk),
        .rst        (rst),
        .read_pulse (diag_read),
        .perm_mode  (perm_reg),
        .fault_raw  (fault_s[4*g+3:4*g]),
        .offset_raw (offset_s[g]),
        .overload   (ovl_s[g]),
        .offset_en  (cb1_reg[`AOFD_CB1_OFFSET_EN]),
        .fault_rep  (fault_rep[4*g+3:4*g]),
        .offset_rep (offset_rep[g])
      );
    end
  endgenerate

  // Start-up safety sequence state machine
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_STBY: begin
        cnt_next = {`AOFD_CNT_W{1'b0}};
        if (!standby) begin
          state_next = ST_MUTED;
        end
      end
      ST_MUTED: begin
        if (play_cmd) begin
          cnt_next = {`AOFD_CNT_W{1'b0}};
          if (ssr_on && !checked_reg) begin
            state_next = ST_CHECK;
          end else begin
            state_next = ST_PLAY;
          end
        end
      end
      ST_CHECK: begin
        cnt_next = cnt_reg + 1'b1;
        if (any_offset) begin
          state_next = ST_SHUT;
        end else if (cnt_reg == `AOFD_SSR_MUTE_CYC) begin
          state_next = ST_PLAY;
          cnt_next   = {`AOFD_CNT_W{1'b0}};
        end
      end
      ST_PLAY: begin
        // Muting returns to the muted state; the start check stays done
        if (mute_cmd) begin
          state_next = ST_MUTED;
        end else if (cnt_reg != `AOFD_SILENT_CYC) begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      ST_SHUT: begin
        cnt_next = cnt_reg;
      end
      default: begin
        state_next = ST_STBY;
        cnt_next   = {`AOFD_CNT_W{1'b0}};
      end
    endcase
    if (standby) begin
      state_next = ST_STBY;
    end
  end

  // Sequence registers; shutdown flag persists until standby
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg    <= ST_STBY;
      cnt_reg      <= {`AOFD_CNT_W{1'b0}};
      checked_reg  <= 1'b0;
      ssr_shut_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      if (standby) begin
        checked_reg  <= 1'b0;
        ssr_shut_reg <= 1'b0;
      end else begin
        if (state_reg == ST_CHECK) begin
          checked_reg <= 1'b1;
        end
        if (state_next == ST_SHUT) begin
          ssr_shut_reg <= 1'b1;
        end
      end
    end
  end

  // Permanent mode after the first read past turn-on; thermal registered every cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      perm_reg     <= 1'b0;
      perm_rep_reg <= 1'b0;
      therm_reg    <= 3'h0;
    end else begin
      // Mode bit travels with the report it describes, so turn-on
      // data that still shows an open load is not marked permanent
      if (diag_read) begin
        perm_rep_reg <= perm_reg;
      end
      if (standby) begin
        perm_reg <= 1'b0;
      end else if (diag_read && state_reg == ST_PLAY) begin
        perm_reg <= 1'b1;
      end
      therm_reg <= therm_s;
    end
  end

  // Mute ramp timer; it stops at the short fast mute count in every mode
  assign mute_done = (mcnt_reg == `AOFD_FAST_MUTE_CYC);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mute_req_reg <= 1'b1;
      mcnt_reg     <= {`AOFD_CNT_W{1'b0}};
    end else begin
      mute_req_reg <= (state_next != ST_PLAY);
      if (state_next == ST_PLAY) begin
        mcnt_reg <= {`AOFD_CNT_W{1'b0}};
      end else if (!mute_done) begin
        mcnt_reg <= mcnt_reg + 1'b1;
      end
    end
  end

  // Outputs, all registered
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      amp_enable      <= 1'b0;
      mute_out        <= 1'b1;
      fast_mute_out   <= 1'b0;
      audio_ready     <= 1'b0;
      diag_byte_one   <= 8'h00;
      diag_byte_two   <= 8'h00;
      diag_byte_three <= 8'h00;
      diag_byte_four  <= 8'h00;
    end else begin
      amp_enable    <= (state_next != ST_STBY) && (state_next != ST_SHUT);
      mute_out      <= mute_req_reg;
      // Fast mute: the ramp is declared finished under 1.5 ms
      fast_mute_out <= mute_req_reg & cb2_reg[`AOFD_CB2_FAST_MUTE] &
                       ~mute_done;
      audio_ready   <= (state_reg == ST_PLAY) &&
                       (cnt_reg == `AOFD_SILENT_CYC);
      // Each channel byte holds its faults; one read per cycle rolls on
      diag_byte_one   <= {therm_reg[0], perm_rep_reg, offset_rep[0], 1'b0,
                          fault_rep[3:0]};
      diag_byte_two   <= {therm_reg[1], ssr_shut_reg, offset_rep[1],
                          1'b0, fault_rep[7:4]};
      diag_byte_three <= {therm_reg[2], 1'b0, offset_rep[2], 1'b0,
                          fault_rep[11:8]};
      diag_byte_four  <= {1'b0, 1'b0, offset_rep[3], 1'b0,
                          fault_rep[15:12]};
    end
  end
endmodule // aofd_ctrl

// ### aofd_props.sv
// Purpose: Port assertions for aofd_ctrl
// Assumes: One clock, async active-high reset
// Notes:   Bounds follow the hand-over latencies
`timescale 1ns/1ps
module aofd_props (
  input wire       clk,
  input wire       rst,
  input wire       standby_pin_n,
  input wire [7:0] control_byte_two,
  input wire       cb2_wr,
  input wire       diag_read,
  input wire       amp_enable,
  input wire       fast_mute_out,
  input wire [7:0] diag_byte_one,
  input wire [7:0] diag_byte_two,
  input wire [7:0] diag_byte_four
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // No read for three cycles while the amp is enabled
  sequence quiet3;
    (!diag_read && amp_enable) [*3];
  endsequence
  stby_cmd_a: assert property (
    cb2_wr && !control_byte_two[4] |-> ##[1:4] !amp_enable)
    else $error("standby write left amp on");
  stby_pin_a: assert property (
    !standby_pin_n [*4] |=> !amp_enable)
    else $error("standby pin left amp on");
  fast_mute_a: assert property (
    $rose(fast_mute_out) |-> ##[1:300] !fast_mute_out)
    else $error("fast mute too long");
  shut_flag_a: assert property (
    diag_byte_two[6] |-> !amp_enable)
    else $error("shutdown flag with amp on");
  // Standby clears only byte two bit 6, yet a drop of the amp excuses a change
  read_hold_a: assert property (
    quiet3 |=> $stable(diag_byte_four) || !amp_enable)
    else $error("diag byte moved without read");
  perm_open_a: assert property (
    diag_byte_one[6] |-> !diag_byte_one[3])
    else $error("open load in permanent mode");
  rail_mask_a: assert property (
    |diag_byte_one[1:0] |-> diag_byte_one[3:2] == 2'b00)
    else $error("rail short did not mask");
  rail_mask4_a: assert property (
    |diag_byte_four[1:0] |-> diag_byte_four[3:2] == 2'b00)
    else $error("rail short did not mask");
endmodule // aofd_props

bind aofd_ctrl aofd_props i_aofd_props (
  .clk(clk), .rst(rst), .standby_pin_n(standby_pin_n),
  .control_byte_two(control_byte_two), .cb2_wr(cb2_wr),
  .diag_read(diag_read), .amp_enable(amp_enable),
  .fast_mute_out(fast_mute_out), .diag_byte_one(diag_byte_one),
  .diag_byte_two(diag_byte_two), .diag_byte_four(diag_byte_four));

// ### aofd_host.sv
// Purpose: Host model issuing control writes and diagnostic reads
// Assumes: Strobes launch at the falling edge and last one cycle
// Notes:   Released bytes are inverted so stale data is never trusted
`timescale 1ns/1ps
module aofd_host (
  input  wire       clk,
  output reg  [7:0] control_byte_one,
  output reg        cb1_wr,
  output reg  [7:0] control_byte_two,
  output reg        cb2_wr,
  output reg        diag_read
);
  // Power up muted and in standby
  initial begin
    control_byte_one = 8'h00;
    control_byte_two = 8'h00;
    cb1_wr = 1'b0;
    cb2_wr = 1'b0;
    diag_read = 1'b0;
  end
  // First control byte; play is sent with no input signal
  task wr1(input [7:0] b);
    begin
      @(negedge clk);
      control_byte_one = b;
      cb1_wr = 1'b1;
      @(negedge clk);
      cb1_wr = 1'b0;
      control_byte_one = ~b;
    end
  endtask
  // Second control byte; fast mute is cleared by a later write
  task wr2(input [7:0] b);
    begin
      @(negedge clk);
      control_byte_two = b;
      cb2_wr = 1'b1;
      @(negedge clk);
      cb2_wr = 1'b0;
      control_byte_two = ~b;
    end
  endtask
  // Read pulse, then wait out the two-edge answer
  task rd;
    begin
      @(negedge clk);
      diag_read = 1'b1;
      @(negedge clk);
      diag_read = 1'b0;
      repeat (3) @(negedge clk);
    end
  endtask
endmodule // aofd_host

// ### aofd_ctrl_test.sv
// Purpose: Self-checking bench for aofd_ctrl
// Assumes: 200 MHz clock, inputs driven at the falling edge
// Notes:   The 40 ms and 100 ms counts are never run out
`timescale 1ns/1ps
module aofd_ctrl_test;
  reg         clk, rst, standby_pin_n;
  reg  [15:0] fault_pins;
  reg  [3:0]  offset_pins, overload_pins;
  reg  [2:0]  thermal_pins;
  wire [7:0]  control_byte_one, control_byte_two;
  wire        cb1_wr, cb2_wr, diag_read;
  wire        amp_enable, mute_out, fast_mute_out, audio_ready;
  wire [7:0]  diag_byte_one, diag_byte_two, diag_byte_three;
  wire [7:0]  diag_byte_four;
  integer     err_total, samples_checked, i;

  aofd_host i_aofd_host (.clk(clk), .control_byte_one(control_byte_one),
    .cb1_wr(cb1_wr), .control_byte_two(control_byte_two),
    .cb2_wr(cb2_wr), .diag_read(diag_read));
  aofd_ctrl i_aofd_ctrl (.clk(clk), .rst(rst),
    .standby_pin_n(standby_pin_n), .control_byte_one(control_byte_one),
    .cb1_wr(cb1_wr), .control_byte_two(control_byte_two),
    .cb2_wr(cb2_wr), .diag_read(diag_read), .fault_pins(fault_pins),
    .offset_pins(offset_pins), .overload_pins(overload_pins),
    .thermal_pins(thermal_pins), .amp_enable(amp_enable),
    .mute_out(mute_out), .fast_mute_out(fast_mute_out),
    .audio_ready(audio_ready), .diag_byte_one(diag_byte_one),
    .diag_byte_two(diag_byte_two), .diag_byte_three(diag_byte_three),
    .diag_byte_four(diag_byte_four));

  // Compare and count
  task chk(input [7:0] got, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Bounded wait for the amplifier state
  task wait_amp(input v);
    for (i = 0; i < 60 && amp_enable !== v; i = i + 1) @(negedge clk);
  endtask
  // Start-up offset shuts down, standby pin clears it
  task t_ssr;
    begin
      chk({6'h00, amp_enable, mute_out}, 8'h01);
      i_aofd_host.wr2(8'h11);
      standby_pin_n = 1'b1;
      wait_amp(1'b1);
      chk({6'h00, amp_enable, mute_out}, 8'h03);
      i_aofd_host.wr1(8'h06);
      repeat (20) @(negedge clk);
      chk({7'h00, amp_enable}, 8'h01);
      chk({7'h00, audio_ready}, 8'h00);
      offset_pins = 4'h4;
      wait_amp(1'b0);
      chk({7'h00, amp_enable}, 8'h00);
      i_aofd_host.rd;
      chk({7'h00, diag_byte_two[6]}, 8'h01);
      standby_pin_n = 1'b0;
      offset_pins = 4'h0;
      repeat (8) @(negedge clk);
      chk({7'h00, diag_byte_two[6]}, 8'h00);
    end
  endtask
  // Faults, masking, offset window and thermal bits over reads
  task t_diag;
    begin
      standby_pin_n = 1'b1;
      i_aofd_host.wr2(8'h10);
      wait_amp(1'b1);
      i_aofd_host.wr1(8'h66);
      offset_pins = 4'h4;
      fault_pins = 16'hA089;
      thermal_pins = 3'b101;
      i_aofd_host.rd;
      chk({4'h0, diag_byte_one[3:0]}, 8'h00);
      i_aofd_host.rd;
      chk({4'h0, diag_byte_one[3:0]}, 8'h01);
      chk({4'h0, diag_byte_two[3:0]}, 8'h00);
      chk({4'h0, diag_byte_four[3:0]}, 8'h02);
      chk({7'h00, diag_byte_three[5]}, 8'h01);
      chk({5'h00, diag_byte_one[7], diag_byte_two[7],
           diag_byte_three[7]}, 8'h05);
      fault_pins = 16'h0000;
      overload_pins = 4'h4;
      repeat (5) @(negedge clk);
      overload_pins = 4'h0;
      i_aofd_host.rd;
      chk({7'h00, diag_byte_three[5]}, 8'h00);
      chk({4'h0, diag_byte_one[3:0]}, 8'h00);
    end
  endtask
  // Fast mute ramp, then standby by command
  task t_fast;
    begin
      i_aofd_host.wr2(8'h30);
      i_aofd_host.wr1(8'h40);
      for (i = 0; i < 20 && fast_mute_out !== 1'b1; i = i + 1)
        @(negedge clk);
      chk({7'h00, fast_mute_out}, 8'h01);
      for (i = 0; i < 300 && fast_mute_out !== 1'b0; i = i + 1)
        @(negedge clk);
      chk({6'h00, fast_mute_out, mute_out}, 8'h01);
      i_aofd_host.wr2(8'h10);
      i_aofd_host.wr2(8'h00);
      wait_amp(1'b0);
      chk({7'h00, amp_enable}, 8'h00);
    end
  endtask
  // Report and stop
  task wrap_up;
    begin
      $display("checks=%0d errors=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    standby_pin_n = 1'b0;
    fault_pins = 16'h0000;
    offset_pins = 4'h0;
    overload_pins = 4'h0;
    thermal_pins = 3'b000;
    err_total = 0;
    samples_checked = 0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_ssr;
    t_diag;
    t_fast;
    wrap_up;
  end
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    err_total = err_total + 1;
    wrap_up;
  end
endmodule // aofd_ctrl_test
